// [upte_pkg.sv]
`default_nettype none
package upte_pkg;

  // ****************************************
  // clock and counter width
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TIMER_W       = 21;

  // ****************************************
  // times as printed, then cycle counts
  // ****************************************
  // least times round up, longest times round down
  localparam int unsigned LTM_REPEAT_WINDOW_MS = 1;
  localparam int unsigned LTM_REPEAT_WINDOW_CYC =
    (LTM_REPEAT_WINDOW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LTM_NOTIFY_MS  = 10;
  localparam int unsigned LTM_NOTIFY_CYC =
    (LTM_NOTIFY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned GEN2_GAP_NS  = 50;
  localparam int unsigned GEN2_GAP_CYC = GEN2_GAP_NS / CLK_PERIOD_NS;
  localparam int unsigned GEN1_GAP_NS  = 100;
  localparam int unsigned GEN1_GAP_CYC = GEN1_GAP_NS / CLK_PERIOD_NS;
  localparam int unsigned HUB_GAP_NS   = 50;
  localparam int unsigned HUB_GAP_CYC  = HUB_GAP_NS / CLK_PERIOD_NS;
  localparam int unsigned TPF_NOTIFY_NS  = 400;
  localparam int unsigned TPF_NOTIFY_CYC = TPF_NOTIFY_NS / CLK_PERIOD_NS;
  localparam int unsigned ITP_JITTER_US  = 33;
  localparam int unsigned ITP_JITTER_CYC =
    (ITP_JITTER_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LDM_REQ_TIMEOUT_US  = 125;
  localparam int unsigned LDM_REQ_TIMEOUT_CYC =
    (LDM_REQ_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LDM_GIVEUP_US  = 125;
  localparam int unsigned LDM_GIVEUP_CYC =
    (LDM_GIVEUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LDM_RESP_US  = 3;
  localparam int unsigned LDM_RESP_CYC = (LDM_RESP_US * 1000) / CLK_PERIOD_NS;

  // ****************************************
  // short limits at counter width
  // ****************************************
  localparam logic [TIMER_W-1:0] GEN2_GAP_LIM   = TIMER_W'(GEN2_GAP_CYC);
  localparam logic [TIMER_W-1:0] GEN1_GAP_LIM   = TIMER_W'(GEN1_GAP_CYC);
  localparam logic [TIMER_W-1:0] HUB_GAP_LIM    = TIMER_W'(HUB_GAP_CYC);
  localparam logic [TIMER_W-1:0] TPF_NOTIFY_LIM = TIMER_W'(TPF_NOTIFY_CYC);
  localparam logic [TIMER_W-1:0] LDM_RESP_LIM   = TIMER_W'(LDM_RESP_CYC);

  // ****************************************
  // delay measurement responder states
  // ****************************************
  typedef enum logic [2:0] {
    LDM_IDLE = 3'h1,
    LDM_DUE  = 3'h2,
    LDM_LATE = 3'h4
  } upte_ldm_state_t;

endpackage : upte_pkg
`default_nettype wire

// [upte_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module upte_timer #(
  parameter int unsigned W = 21
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] limit,
  input  wire logic         start,
  input  wire logic         stop,
  output logic              running,
  output logic              expired
);

  logic [W-1:0] cnt;
  wire          at_end = running && (cnt == limit - W'(1));

  // start beats stop so a fresh event is never lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt     <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt     <= '0;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (stop) begin
      running <= 1'b0;
      expired <= 1'b0;
    end else if (at_end) begin
      running <= 1'b0;
      expired <= 1'b1;
    end else begin
      expired <= 1'b0;
      if (running) begin
        cnt <= cnt + W'(1);
      end
    end
  end

endmodule : upte_timer
`default_nettype wire

// [upte_gap.sv]
`timescale 1ns/1ns
`default_nettype none
module upte_gap #(
  parameter int unsigned W = 21
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] limit,
  input  wire logic         pkt_start,
  input  wire logic         pkt_end,
  input  wire logic         more,
  output logic              send_now,
  output logic              gap_over
);

  logic [W-1:0] gap;
  logic         open;
  wire          open_gap = pkt_end && more;
  wire          close    = pkt_start || !more;
  wire          too_long = open && (gap == limit - W'(1));

  // ****************************************
  // gap between data packets of one burst
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap      <= '0;
      open     <= 1'b0;
      gap_over <= 1'b0;
    end else if (open_gap) begin
      gap      <= '0;
      open     <= 1'b1;
      gap_over <= 1'b0;
    end else if (close) begin
      open     <= 1'b0;
      gap_over <= 1'b0;
    end else if (too_long) begin
      open     <= 1'b0;
      gap_over <= 1'b1;
    end else begin
      gap_over <= 1'b0;
      if (open) begin
        gap <= gap + W'(1);
      end
    end
  end

  // the sender must start the next packet while this is high
  assign send_now = open;

endmodule : upte_gap
`default_nettype wire

// [upte_top.sv]
`timescale 1ns/1ns
`default_nettype none
module upte_top #(
  parameter int unsigned LTM_WINDOW_CYC  = upte_pkg::LTM_REPEAT_WINDOW_CYC,
  parameter int unsigned LTM_NOTIFY_CYC  = upte_pkg::LTM_NOTIFY_CYC,
  parameter int unsigned ITP_JITTER_CYC  = upte_pkg::ITP_JITTER_CYC,
  parameter int unsigned LDM_REQ_CYC     = upte_pkg::LDM_REQ_TIMEOUT_CYC,
  parameter int unsigned LDM_GIVEUP_CYC  = upte_pkg::LDM_GIVEUP_CYC
) (
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  input  wire logic GEN2_MODE,
  input  wire logic LTM_SENT,
  input  wire logic LTM_FEATURE_DONE,
  output logic      LTM_ALLOW,
  output logic      LTM_NOTIFY_DUE,
  output logic      LTM_NOTIFY_LATE,
  input  wire logic EP_DP_START,
  input  wire logic EP_DP_END,
  input  wire logic EP_BURST_MORE,
  output logic      EP_SEND_NOW,
  output logic      EP_GAP_OVER,
  input  wire logic HUB_DP_START,
  input  wire logic HUB_DP_END,
  input  wire logic HUB_BUFFERED,
  output logic      HUB_SEND_NOW,
  output logic      HUB_GAP_OVER,
  input  wire logic TPF_TP_END,
  input  wire logic DEV_NOTIFY_START,
  output logic      DEV_NOTIFY_DUE,
  output logic      DEV_NOTIFY_LATE,
  input  wire logic ITP_RX_END,
  input  wire logic ITP_TX_START,
  output logic      ITP_REGEN_DUE,
  output logic      ITP_JITTER_OVER,
  input  wire logic LDM_REQ_SENT,
  input  wire logic LDM_RESP_RCVD,
  output logic      LDM_REQ_PENDING,
  output logic      LDM_REQ_ABANDON,
  input  wire logic LDM_TS_REQ_RCVD,
  input  wire logic LDM_RESP_START,
  output logic      LDM_RESP_DUE,
  output logic      LDM_RESP_URGENT,
  output logic      LDM_RESP_LATE,
  output logic      LDM_RESP_GIVEUP
);
  import upte_pkg::*;

  // ****************************************
  // long limits, shortened by parameters
  // ****************************************
  localparam logic [TIMER_W-1:0] LTM_WIN_LIM  = TIMER_W'(LTM_WINDOW_CYC);
  localparam logic [TIMER_W-1:0] LTM_NTF_LIM  = TIMER_W'(LTM_NOTIFY_CYC);
  localparam logic [TIMER_W-1:0] ITP_LIM      = TIMER_W'(ITP_JITTER_CYC);
  localparam logic [TIMER_W-1:0] LDM_REQ_LIM  = TIMER_W'(LDM_REQ_CYC);
  localparam logic [TIMER_W-1:0] LDM_GIVE_LIM = TIMER_W'(LDM_GIVEUP_CYC);

  // ****************************************
  // gap limit per link speed
  // ****************************************
  // the hub has only a Gen 2 figure of its own; at the slower
  // speed both streams fall back to the Gen 1 figure
  function automatic logic [TIMER_W-1:0] gap_limit(
    input logic               gen2,
    input logic [TIMER_W-1:0] gen2_lim
  );
    logic [TIMER_W-1:0] lim;
    case (gen2)
      1'b1: begin
        lim = gen2_lim;
      end
      default: begin
        lim = GEN1_GAP_LIM;
      end
    endcase
    return lim;
  endfunction : gap_limit

  // ****************************************
  // latency message pacing
  // ****************************************
  // one window per message sent; a third is held back while both run,
  // which gives an exact sliding window without a timestamp history
  // the sender must honour LTM_ALLOW: a send made while it is low
  // starts no window and is not counted
  logic win_a_run;
  logic win_b_run;
  wire  start_a = LTM_SENT && !win_a_run;
  wire  start_b = LTM_SENT && win_a_run && !win_b_run;

  upte_timer #(.W(TIMER_W)) u_win_a (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LTM_WIN_LIM),
    .start   (start_a),
    .stop    (1'b0),
    .running (win_a_run),
    .expired ()
  );

  upte_timer #(.W(TIMER_W)) u_win_b (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LTM_WIN_LIM),
    .start   (start_b),
    .stop    (1'b0),
    .running (win_b_run),
    .expired ()
  );

  assign LTM_ALLOW = !(win_a_run && win_b_run);

  // ****************************************
  // latency notice after feature change
  // ****************************************
  // notice deadline timer
  upte_timer #(.W(TIMER_W)) u_ltm_ntf (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LTM_NTF_LIM),
    .start   (LTM_FEATURE_DONE),
    .stop    (LTM_SENT),
    .running (LTM_NOTIFY_DUE),
    .expired (LTM_NOTIFY_LATE)
  );

  // ****************************************
  // burst packet spacing
  // ****************************************
  // Gen 2 limit, or the Gen 1 figure at the slower speed
  wire [TIMER_W-1:0] ep_gap_lim  = gap_limit(GEN2_MODE, GEN2_GAP_LIM);
  wire [TIMER_W-1:0] hub_gap_lim = gap_limit(GEN2_MODE, HUB_GAP_LIM);

  upte_gap #(.W(TIMER_W)) u_ep_gap (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .limit     (ep_gap_lim),
    .pkt_start (EP_DP_START),
    .pkt_end   (EP_DP_END),
    .more      (EP_BURST_MORE),
    .send_now  (EP_SEND_NOW),
    .gap_over  (EP_GAP_OVER)
  );

  upte_gap #(.W(TIMER_W)) u_hub_gap (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .limit     (hub_gap_lim),
    .pkt_start (HUB_DP_START),
    .pkt_end   (HUB_DP_END),
    .more      (HUB_BUFFERED),
    .send_now  (HUB_SEND_NOW),
    .gap_over  (HUB_GAP_OVER)
  );

  // ****************************************
  // notification after flagged packet
  // ****************************************
  // the host gives up after milliseconds; we stay inside 400 ns so a
  // late pulse here comes long before the host side would time out
  // notification deadline
  upte_timer #(.W(TIMER_W)) u_tpf (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (TPF_NOTIFY_LIM),
    .start   (TPF_TP_END),
    .stop    (DEV_NOTIFY_START),
    .running (DEV_NOTIFY_DUE),
    .expired (DEV_NOTIFY_LATE)
  );

  // ****************************************
  // timestamp regeneration in a hub
  // ****************************************
  // bound added delay
  upte_timer #(.W(TIMER_W)) u_itp (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (ITP_LIM),
    .start   (ITP_RX_END),
    .stop    (ITP_TX_START),
    .running (ITP_REGEN_DUE),
    .expired (ITP_JITTER_OVER)
  );

  // ****************************************
  // delay measurement request side
  // ****************************************
  // abandon request
  upte_timer #(.W(TIMER_W)) u_ldm_req (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LDM_REQ_LIM),
    .start   (LDM_REQ_SENT),
    .stop    (LDM_RESP_RCVD),
    .running (LDM_REQ_PENDING),
    .expired (LDM_REQ_ABANDON)
  );

  // ****************************************
  // delay measurement responder
  // ****************************************
  logic resp_run;
  logic give_run;

  upte_timer #(.W(TIMER_W)) u_ldm_resp (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LDM_RESP_LIM),
    .start   (LDM_TS_REQ_RCVD),
    .stop    (LDM_RESP_START),
    .running (resp_run),
    .expired (LDM_RESP_LATE)
  );

  upte_timer #(.W(TIMER_W)) u_ldm_give (
    .clk     (CORE_CLK),
    .arst_n  (ARST_N),
    .limit   (LDM_GIVE_LIM),
    .start   (LDM_TS_REQ_RCVD),
    .stop    (LDM_RESP_START),
    .running (give_run),
    .expired (LDM_RESP_GIVEUP)
  );

  upte_ldm_state_t ldm_state;
  upte_ldm_state_t next_ldm_state;

  // a late response is still worth sending until the give-up point
  always_comb begin
    next_ldm_state = ldm_state;
    case (ldm_state)
      LDM_IDLE: begin
        if (LDM_TS_REQ_RCVD) next_ldm_state = LDM_DUE;
      end
      LDM_DUE: begin
        if (LDM_TS_REQ_RCVD) next_ldm_state = LDM_DUE;
        else if (LDM_RESP_START) next_ldm_state = LDM_IDLE;
        else if (LDM_RESP_LATE) next_ldm_state = LDM_LATE;
      end
      LDM_LATE: begin
        if (LDM_TS_REQ_RCVD) next_ldm_state = LDM_DUE;
        else if (LDM_RESP_START) next_ldm_state = LDM_IDLE;
        else if (LDM_RESP_GIVEUP) next_ldm_state = LDM_IDLE;
      end
      default: begin
        next_ldm_state = LDM_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ldm_state <= LDM_IDLE;
    end else begin
      ldm_state <= next_ldm_state;
    end
  end

  // ****************************************
  // responder status outputs
  // ****************************************
  // due stays up through the late state so the link layer keeps
  // the response queued until the give-up point; urgent tells it
  // to put the response ahead of other link traffic
  assign LDM_RESP_DUE    = (ldm_state != LDM_IDLE);
  assign LDM_RESP_URGENT = (ldm_state == LDM_LATE);

endmodule : upte_top
`default_nettype wire

// [upte_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module upte_checker #(
  parameter int LTM_WINDOW_CYC = 20,
  parameter int ITP_JITTER_CYC = 40,
  parameter int LDM_REQ_CYC    = 50,
  parameter int LDM_GIVEUP_CYC = 400
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic GEN2_MODE,
  input wire logic LTM_ALLOW,
  input wire logic EP_DP_END,
  input wire logic EP_GAP_OVER,
  input wire logic HUB_DP_END,
  input wire logic HUB_GAP_OVER,
  input wire logic TPF_TP_END,
  input wire logic DEV_NOTIFY_LATE,
  input wire logic ITP_RX_END,
  input wire logic ITP_JITTER_OVER,
  input wire logic LDM_REQ_SENT,
  input wire logic LDM_REQ_ABANDON,
  input wire logic LDM_TS_REQ_RCVD,
  input wire logic LDM_RESP_LATE,
  input wire logic LDM_RESP_GIVEUP
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // ****************************************
  // deadlines counted from their cause, pacing from LTM_ALLOW low
  // ****************************************
  AST_LTM_PACE: assert property (
    !LTM_ALLOW |-> ##[1:LTM_WINDOW_CYC] LTM_ALLOW)
    else $error("latency message window overran");
  AST_EP_GAP: assert property (
    EP_GAP_OVER |-> (GEN2_MODE ? $past(EP_DP_END, 7) : $past(EP_DP_END, 13)))
    else $error("endpoint gap flagged at wrong time");
  AST_HUB_GAP: assert property (
    HUB_GAP_OVER |-> (GEN2_MODE ? $past(HUB_DP_END, 7)
                                : $past(HUB_DP_END, 13)))
    else $error("hub gap flagged at wrong time");
  AST_TPF_LATE: assert property (
    DEV_NOTIFY_LATE |-> $past(TPF_TP_END, 51))
    else $error("notification lateness at wrong time");
  AST_ITP_JITTER: assert property (
    ITP_JITTER_OVER |-> $past(ITP_RX_END, ITP_JITTER_CYC + 1))
    else $error("regeneration overrun at wrong time");
  AST_LDM_ABANDON: assert property (
    LDM_REQ_ABANDON |-> $past(LDM_REQ_SENT, LDM_REQ_CYC + 1))
    else $error("request abandoned at wrong time");
  AST_RESP_LATE: assert property (
    LDM_RESP_LATE |-> $past(LDM_TS_REQ_RCVD, 376))
    else $error("response lateness at wrong time");
  AST_GIVEUP: assert property (
    LDM_RESP_GIVEUP |-> $past(LDM_TS_REQ_RCVD, LDM_GIVEUP_CYC + 1))
    else $error("responder gave up at wrong time");
  COV_ABANDON: cover property (LDM_REQ_ABANDON);
  COV_GIVEUP: cover property (LDM_RESP_GIVEUP);
  COV_GAP: cover property (GEN2_MODE && EP_GAP_OVER);
endmodule : upte_checker
`default_nettype wire

// [upte_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module upte_host_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic req_sent,
  input  wire logic slow,
  output logic      resp_rcvd
);
  logic [2:0] cnt;
  // one answer per request unless slow is high, never a retry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt       <= 3'h0;
      resp_rcvd <= 1'b0;
    end else begin
      resp_rcvd <= (cnt == 3'h1);
      if (req_sent && !slow) cnt <= 3'h5;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    end
  end
endmodule : upte_host_model
`default_nettype wire

// [tb_upte_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb_upte_top;
  localparam int LW = 20, LN = 30, LJ = 40, LQ = 50, LG = 400;
  logic        clk, arst_n, gen2, more, hbuf, slow, resp;
  logic [12:0] pl;
  wire  [16:0] ob;
  logic [31:0] seed;
  int          fails, tests_run;

  upte_top #(.LTM_WINDOW_CYC(LW), .LTM_NOTIFY_CYC(LN), .ITP_JITTER_CYC(LJ),
    .LDM_REQ_CYC(LQ), .LDM_GIVEUP_CYC(LG)) i_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .GEN2_MODE(gen2), .LTM_SENT(pl[0]),
    .LTM_FEATURE_DONE(pl[1]), .LTM_ALLOW(ob[0]), .LTM_NOTIFY_DUE(ob[1]),
    .LTM_NOTIFY_LATE(ob[2]), .EP_DP_START(pl[2]), .EP_DP_END(pl[3]),
    .EP_BURST_MORE(more), .EP_SEND_NOW(ob[3]), .EP_GAP_OVER(ob[4]),
    .HUB_DP_START(pl[4]), .HUB_DP_END(pl[5]), .HUB_BUFFERED(hbuf),
    .HUB_SEND_NOW(ob[5]), .HUB_GAP_OVER(ob[6]), .TPF_TP_END(pl[6]),
    .DEV_NOTIFY_START(pl[7]), .DEV_NOTIFY_DUE(ob[7]),
    .DEV_NOTIFY_LATE(ob[8]), .ITP_RX_END(pl[8]), .ITP_TX_START(pl[9]),
    .ITP_REGEN_DUE(ob[9]), .ITP_JITTER_OVER(ob[10]),
    .LDM_REQ_SENT(pl[10]), .LDM_RESP_RCVD(resp), .LDM_REQ_PENDING(ob[11]),
    .LDM_REQ_ABANDON(ob[12]), .LDM_TS_REQ_RCVD(pl[11]),
    .LDM_RESP_START(pl[12]), .LDM_RESP_DUE(ob[13]),
    .LDM_RESP_URGENT(ob[14]), .LDM_RESP_LATE(ob[15]),
    .LDM_RESP_GIVEUP(ob[16]));
  upte_host_model i_host (.clk(clk), .arst_n(arst_n), .req_sent(pl[10]),
    .slow(slow), .resp_rcvd(resp));

  // ****************************************
  // drivers and checks
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic pulse(input int b);
    @(posedge clk); pl[b] <= 1'b1;
    @(posedge clk); pl[b] <= 1'b0;
  endtask : pulse
  // value as sampled d edges on
  task automatic chk_at(input int d, input int b, input logic v);
    repeat (d) @(negedge clk);
    `CHK(ob[b], v)
  endtask : chk_at
  task automatic tmr(input int sb, lv, ex, len);
    pulse(sb); chk_at(1, lv, 1'b1); chk_at(len - 1, ex, 1'b0);
    chk_at(1, ex, 1'b1); `CHK(ob[lv], 1'b0)
    chk_at(1, ex, 1'b0);
  endtask : tmr
  task automatic tmr_stop(input int sb, stb, lv, ex, len);
    int d;
    d = int'(rnd() % 32'(len - 2)) + 1;
    pulse(sb); repeat (d) @(posedge clk); pulse(stb);
    chk_at(1, lv, 1'b0); chk_at(len, ex, 1'b0);
  endtask : tmr_stop
  task automatic gap(input int hub, input logic close, input logic g);
    int   l, s, lv;
    l = g ? 6 : 12; s = hub ? 4 : 2; lv = hub ? 5 : 3;
    @(posedge clk); gen2 <= g;
    pulse(s + 1); chk_at(1, lv, 1'b1);
    if (close) begin
      pulse(s); chk_at(1, lv, 1'b0);
    end else begin
      chk_at(l - 1, lv + 1, 1'b0); chk_at(1, lv + 1, 1'b1);
      `CHK(ob[lv], 1'b0)
    end
  endtask : gap
  task report_and_stop;
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial begin
    arst_n = 1'b0; gen2 = 1'b0; more = 1'b1; hbuf = 1'b1; slow = 1'b1;
    pl = '0; seed = 32'hC8ED; fails = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk); `CHK(ob, 17'h00001)
    pulse(0); pulse(0); chk_at(1, 0, 1'b0);
    chk_at(LW - 3, 0, 1'b0); chk_at(1, 0, 1'b1);
    tmr(1, 1, 2, LN);
    tmr_stop(1, 0, 1, 2, LN);
    // host waits far longer than this deadline
    tmr(6, 7, 8, 50);
    tmr_stop(6, 7, 7, 8, 50);
    // host starts timestamps once the link is up
    tmr(8, 9, 10, LJ);
    tmr_stop(8, 9, 9, 10, LJ);
    tmr(10, 11, 12, LQ);
    @(posedge clk); slow <= 1'b0;
    pulse(10); chk_at(6, 11, 1'b1); chk_at(2, 11, 1'b0);
    tmr_stop(11, 12, 13, 15, 375);
    pulse(11); chk_at(1, 13, 1'b1); chk_at(374, 15, 1'b0);
    chk_at(1, 15, 1'b1); chk_at(1, 14, 1'b1);
    chk_at(LG - 377, 16, 1'b0); chk_at(1, 16, 1'b1);
    chk_at(1, 13, 1'b0);
    // mid-run reset clears a running deadline
    pulse(1); @(posedge clk); arst_n <= 1'b0;
    @(negedge clk); `CHK(ob, 17'h00001)
    @(posedge clk); arst_n <= 1'b1;
    @(negedge clk); `CHK(ob, 17'h00001)
    for (int i = 0; i < 14; i++) begin
      logic c, m;
      c = (i < 4) ? 1'b0 : (i < 6) ? 1'b1 : 1'(rnd());
      m = (i < 4) ? 1'(i / 2) : 1'(rnd());
      gap(i % 2, c, m);
    end
    pulse(3); more <= 1'b0; chk_at(1, 3, 1'b1); chk_at(1, 3, 1'b0);
    pulse(5); hbuf <= 1'b0; chk_at(1, 5, 1'b1); chk_at(1, 5, 1'b0);
    report_and_stop;
  end
endmodule : tb_upte_top
bind upte_top upte_checker #(.LTM_WINDOW_CYC(LTM_WINDOW_CYC),
  .ITP_JITTER_CYC(ITP_JITTER_CYC), .LDM_REQ_CYC(LDM_REQ_CYC),
  .LDM_GIVEUP_CYC(LDM_GIVEUP_CYC)) i_chk (.CORE_CLK, .ARST_N, .GEN2_MODE,
  .LTM_ALLOW, .EP_DP_END, .EP_GAP_OVER, .HUB_DP_END, .HUB_GAP_OVER,
  .TPF_TP_END, .DEV_NOTIFY_LATE, .ITP_RX_END, .ITP_JITTER_OVER,
  .LDM_REQ_SENT, .LDM_REQ_ABANDON, .LDM_TS_REQ_RCVD, .LDM_RESP_LATE,
  .LDM_RESP_GIVEUP);
`default_nettype wire
